// ==== logic/serial_mode_pkg.sv ====
package serial_mode_pkg;

   // Register byte addresses
   localparam logic [15:0] MODE_OFF = 16'hFF78;
   localparam logic [15:0] CTRL_OFF = 16'hFF80;
   localparam logic [15:0] TXD_OFF  = 16'hFF84;
   localparam logic [15:0] RXD_OFF  = 16'hFF88;
   localparam logic [15:0] STAT_OFF = 16'hFF8C;
   localparam logic [15:0] MASK_OFF = 16'hFF90;

   // Serial mode register fields
   localparam int MODE_TOP    = 7;
   localparam int CHAR7       = 6;
   localparam int PARITY_EN   = 5;
   localparam int PARITY_ODD  = 4;
   localparam int STOP2       = 3;
   localparam int MULTIPROC   = 2;
   localparam int CLKSEL_HI   = 1;
   localparam int CLKSEL_LO   = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // Control register fields
   localparam int CTL_SMART   = 0;
   localparam int CTL_CLK_ON  = 1;
   localparam int CTL_CLK_FIX = 2;
   localparam int CTL_CLK_LVL = 3;
   localparam int CTL_DIV_LSB = 8;
   localparam logic [3:0] CTRL_RESET    = 4'h0;
   localparam logic [7:0] HALFDIV_RESET = 8'h07;

   // Status and mask bits
   localparam int ST_TXEND   = 0;
   localparam int ST_RXFULL  = 1;
   localparam int ST_PARERR  = 2;
   localparam int ST_FRAMERR = 3;
   localparam logic [3:0] STAT_RESET = 4'h0;

   // Prescaler terminal counts for the clock select codes
   localparam logic [5:0] PRE_DIV1  = 6'h00;
   localparam logic [5:0] PRE_DIV4  = 6'h03;
   localparam logic [5:0] PRE_DIV16 = 6'h0F;
   localparam logic [5:0] PRE_DIV64 = 6'h3F;

   // Transmit-end point in half bit times (12.5 and 11.0 etu)
   localparam logic [4:0] TRANSMIT_END_FLAG_NORMAL_HALVES = 5'h19;
   localparam logic [4:0] TRANSMIT_END_FLAG_ALT_HALVES    = 5'h16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [15:0] araddr;
      logic        arvalid;
      logic        rready;
   } axiReq_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axiResp_s;

endpackage : serial_mode_pkg

// ==== logic/baud_gen.sv ====
module baud_gen
   import serial_mode_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] clkSel,
   input  wire logic [7:0] halfDiv,
   output logic            halfTick,
   output logic            cardPhase
);

   typedef struct packed {
      logic [5:0] preCnt;
      logic [7:0] divCnt;
      logic       halfTick;
      logic       cardPhase;
   } state_s;

   state_s s;
   state_s next_s;
   logic [5:0] preLimit;

   always_comb
   begin
      case (clkSel)
         2'h0:    preLimit = PRE_DIV1;
         2'h1:    preLimit = PRE_DIV4;
         2'h2:    preLimit = PRE_DIV16;
         default: preLimit = PRE_DIV64;
      endcase
      next_s = s;
      next_s.halfTick = 1'b0;
      // A code change mid-count applies at once; a count already past the new limit wraps next
      if (s.preCnt >= preLimit)
      begin
         next_s.preCnt = 6'h00;
         next_s.cardPhase = ~s.cardPhase;
         if (s.divCnt >= halfDiv)
         begin
            next_s.divCnt = 8'h00;
            next_s.halfTick = 1'b1;
         end
         else
         begin
            next_s.divCnt = s.divCnt + 8'h01;
         end
      end
      else
      begin
         next_s.preCnt = s.preCnt + 6'h01;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign halfTick  = s.halfTick;
   assign cardPhase = s.cardPhase;

endmodule : baud_gen

// ==== logic/serial_mode_config.sv ====
module serial_mode_config
   import serial_mode_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      rst_n,
   input  wire axiReq_s   axiReq,
   output axiResp_s       axiResp,
   input  wire logic      rxd,
   output logic           txd,
   output logic           serialClk,
   output logic           cardClk,
   output logic           irq
);

   typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} txState_e;
   typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_RECV = 2'h2} rxState_e;

   typedef struct packed {
      logic [7:0]  mode;
      logic [3:0]  ctrl;
      logic [7:0]  halfDiv;
      logic [8:0]  txData;
      logic [7:0]  rxData;
      logic [3:0]  status;
      logic [3:0]  mask;
      txState_e    tx;
      logic        txPend;
      logic [4:0]  txHalf;
      logic [4:0]  txEndCnt;
      logic [15:0] txFrame;
      logic        txd;
      logic        sclk;
      logic        cardClk;
      rxState_e    rx;
      logic [4:0]  rxHalf;
      logic [11:0] rxRaw;
      logic [1:0]  rxSync;
      logic        awGot;
      logic        wGot;
      logic [15:0] waddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_s;

   state_s s;
   state_s next_s;
   logic   halfTick;
   logic   cardPhase;
   logic   smart;
   logic   syncMode;
   logic   txFire;
   logic   doWrite;
   logic [3:0] stSet;
   logic [3:0] stClr;
   logic [3:0] rxLen;
   logic [3:0] rxIdx;
   logic [3:0] nData;
   logic [7:0] rxByte;
   logic [20:0] built;

   // Builds the frame LSB first; returns {length in bits, bits}
   function automatic logic [20:0] buildFrame(input logic [7:0] md,
                                              input logic [8:0] d,
                                              input logic       sy);
      logic [15:0] f;
      logic [4:0]  n;
      logic [7:0]  dm;
      logic        par;
      f = 16'hFFFF;
      n = 5'h00;
      dm = md[CHAR7] ? {1'b0, d[6:0]} : d[7:0];
      par = (^dm) ^ md[PARITY_ODD];
      if (!sy)
      begin
         f[n[3:0]] = 1'b0;
         n = n + 5'h01;
      end
      for (int i = 0; i < 8; i++)
      begin
         if (i < 7 || !md[CHAR7])
         begin
            f[n[3:0]] = dm[i];
            n = n + 5'h01;
         end
      end
      if (!sy)
      begin
         if (md[PARITY_EN])
         begin
            f[n[3:0]] = par;
            n = n + 5'h01;
         end
         if (md[MULTIPROC])
         begin
            f[n[3:0]] = d[8];
            n = n + 5'h01;
         end
         n = n + (md[STOP2] ? 5'h02 : 5'h01);
      end
      return {n, f};
   endfunction : buildFrame

   baud_gen u_baud (
      .clock     (clock),
      .rst_n     (rst_n),
      .clkSel    (s.mode[CLKSEL_HI:CLKSEL_LO]),
      .halfDiv   (s.halfDiv),
      .halfTick  (halfTick),
      .cardPhase (cardPhase)
   );

   assign smart    = s.ctrl[CTL_SMART];
   assign syncMode = s.mode[MODE_TOP] && !smart;
   assign doWrite  = s.awGot && s.wGot && !s.bvalid;
   assign nData    = s.mode[CHAR7] ? 4'h7 : 4'h8;
   assign rxLen    = 4'h2 + nData + {3'h0, s.mode[PARITY_EN]}
                     + {3'h0, s.mode[MULTIPROC]};
   assign rxIdx    = s.rxHalf[4:1];
   assign built    = buildFrame(s.mode, s.txData, syncMode);
   assign txFire   = s.tx == TX_SEND && halfTick
                     && s.txHalf + 5'h01 == s.txEndCnt;

   always_comb
   begin
      next_s = s;
      stSet  = 4'h0;
      stClr  = 4'h0;
      rxByte = s.rxRaw[8:1] & (s.mode[CHAR7] ? 8'h7F : 8'hFF);
      next_s.rxSync = {s.rxSync[0], rxd};

      // Write channel: address and data taken in either order
      if (axiReq.awvalid && !s.awGot && !s.bvalid)
      begin
         next_s.awGot = 1'b1;
         next_s.waddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !s.wGot && !s.bvalid)
      begin
         next_s.wGot  = 1'b1;
         next_s.wdata = axiReq.wdata;
         next_s.wstrb = axiReq.wstrb;
      end
      if (s.bvalid && axiReq.bready)
         next_s.bvalid = 1'b0;
      if (doWrite)
      begin
         next_s.awGot  = 1'b0;
         next_s.wGot   = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         case (s.waddr[15:2])
            MODE_OFF[15:2]:
               if (s.wstrb[0])
                  next_s.mode = s.wdata[7:0];
            CTRL_OFF[15:2]:
            begin
               if (s.wstrb[0])
                  next_s.ctrl = s.wdata[3:0];
               if (s.wstrb[1])
                  next_s.halfDiv = s.wdata[CTL_DIV_LSB +: 8];
            end
            TXD_OFF[15:2]:
               // A word written while busy is dropped, not queued
               if (s.tx == TX_IDLE && !s.txPend)
               begin
                  next_s.txData = s.wdata[8:0];
                  next_s.txPend = 1'b1;
               end
            STAT_OFF[15:2]:
               if (s.wstrb[0])
                  stClr = s.wdata[3:0];
            MASK_OFF[15:2]:
               if (s.wstrb[0])
                  next_s.mask = s.wdata[3:0];
            RXD_OFF[15:2]: ;
            default:
               next_s.bresp = RESP_SLVERR;
         endcase
      end

      // Read channel
      if (s.rvalid && axiReq.rready)
         next_s.rvalid = 1'b0;
      if (axiReq.arvalid && !s.rvalid)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         case (axiReq.araddr[15:2])
            MODE_OFF[15:2]: next_s.rdata = {24'h00_0000, s.mode};
            CTRL_OFF[15:2]:
               next_s.rdata = {16'h0000, s.halfDiv, 4'h0, s.ctrl};
            TXD_OFF[15:2]:
               next_s.rdata = {s.tx == TX_SEND || s.txPend,
                               22'h00_0000, s.txData};
            RXD_OFF[15:2]:  next_s.rdata = {24'h00_0000, s.rxData};
            STAT_OFF[15:2]: next_s.rdata = {28'h000_0000, s.status};
            MASK_OFF[15:2]: next_s.rdata = {28'h000_0000, s.mask};
            default:
            begin
               next_s.rdata = 32'h0000_0000;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Transmitter, paced in half bit times so 12.5 etu is exact
      case (s.tx)
         TX_IDLE:
         begin
            next_s.txd  = 1'b1;
            next_s.sclk = 1'b1;
            if (s.txPend && halfTick)
            begin
               next_s.tx       = TX_SEND;
               next_s.txPend   = 1'b0;
               next_s.txHalf   = 5'h00;
               next_s.txFrame  = built[15:0];
               next_s.txd      = built[0];
               next_s.sclk     = !syncMode;
               if (smart)
                  next_s.txEndCnt = s.mode[MODE_TOP] ?
                     TRANSMIT_END_FLAG_ALT_HALVES : TRANSMIT_END_FLAG_NORMAL_HALVES;
               else
                  next_s.txEndCnt = {built[19:16], 1'b0};
            end
         end
         TX_SEND:
         begin
            if (halfTick)
            begin
               next_s.txHalf = s.txHalf + 5'h01;
               next_s.txd = s.txFrame[next_s.txHalf[4:1]];
               next_s.sclk = !syncMode || next_s.txHalf[0];
               if (txFire)
               begin
                  next_s.tx   = TX_IDLE;
                  next_s.txd  = 1'b1;
                  next_s.sclk = 1'b1;
                  stSet[ST_TXEND] = 1'b1;
               end
            end
         end
         default: next_s.tx = TX_IDLE;
      endcase

      // Receiver, asynchronous frames only
      case (s.rx)
         RX_IDLE:
            if (!s.rxSync[1] && !syncMode)
            begin
               next_s.rx     = RX_RECV;
               next_s.rxHalf = 5'h00;
               next_s.rxRaw  = 12'hFFF;
            end
         RX_RECV:
            if (halfTick)
            begin
               next_s.rxHalf = s.rxHalf + 5'h01;
               if (next_s.rxHalf[0])
               begin
                  next_s.rxRaw[next_s.rxHalf[4:1]] = s.rxSync[1];
                  if (next_s.rxHalf[4:1] == rxLen - 4'h1)
                  begin
                     next_s.rx = RX_IDLE;
                     next_s.rxData = rxByte;
                     stSet[ST_RXFULL] = 1'b1;
                     stSet[ST_FRAMERR] = !s.rxSync[1];
                     if (s.mode[PARITY_EN])
                        stSet[ST_PARERR] = (^rxByte)
                           ^ s.mode[PARITY_ODD]
                           ^ s.rxRaw[nData + 4'h1];
                  end
               end
            end
         default: next_s.rx = RX_IDLE;
      endcase
      if (rxIdx == 4'h0 && s.rx == RX_RECV && s.rxHalf[0] && s.rxRaw[0])
         next_s.rx = RX_IDLE;

      // Card clock; a fixed level needs alternate timing
      if (smart && s.ctrl[CTL_CLK_ON])
         next_s.cardClk = cardPhase;
      else
         next_s.cardClk = smart && s.mode[MODE_TOP]
                          && s.ctrl[CTL_CLK_FIX]
                          && s.ctrl[CTL_CLK_LVL];

      // Hardware set wins over a same-cycle software clear
      next_s.status = (s.status & ~stClr) | stSet;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s          <= '0;
         s.mode     <= MODE_RESET;
         s.ctrl     <= CTRL_RESET;
         s.halfDiv  <= HALFDIV_RESET;
         s.status   <= STAT_RESET;
         s.tx       <= TX_IDLE;
         s.rx       <= RX_IDLE;
         s.txd      <= 1'b1;
         s.sclk     <= 1'b1;
         s.rxSync   <= 2'h3;
      end
      else
      begin
         s <= next_s;
      end
   end

   always_comb
   begin
      axiResp.awready = !s.awGot && !s.bvalid;
      axiResp.wready  = !s.wGot && !s.bvalid;
      axiResp.bresp   = s.bresp;
      axiResp.bvalid  = s.bvalid;
      axiResp.arready = !s.rvalid;
      axiResp.rdata   = s.rdata;
      axiResp.rresp   = s.rresp;
      axiResp.rvalid  = s.rvalid;
   end

   assign txd       = s.txd;
   assign serialClk = s.sclk;
   assign cardClk   = s.cardClk;
   assign irq       = |(s.status & s.mask);

   mode_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
      $past(!rst_n) |-> s.mode == 8'h00)
      else $error("mode not cleared by reset");

   mode_readback_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      doWrite && s.waddr[15:2] == MODE_OFF[15:2] && s.wstrb[0]
      |=> s.mode == $past(s.wdata[7:0]))
      else $error("mode write not stored");

   transmit_end_flag_normal_a: assert property (@(posedge clock) disable iff (!rst_n)
      txFire && smart && !s.mode[MODE_TOP] |-> s.txHalf == 5'd24)
      else $error("normal transmit end not at 12.5 etu");

   transmit_end_flag_alt_a: assert property (@(posedge clock) disable iff (!rst_n)
      txFire && smart && s.mode[MODE_TOP] |-> s.txHalf == 5'd21)
      else $error("alternate transmit end not at 11.0 etu");

   stop_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
      s.tx == TX_SEND && !smart && !syncMode
      && s.txHalf + (s.mode[STOP2] ? 5'd4 : 5'd2) >= s.txEndCnt
      |-> s.txd)
      else $error("stop bits not high");

   msb_dropped_a: assert property (@(posedge clock) disable iff (!rst_n)
      s.tx == TX_SEND && !syncMode && s.mode[CHAR7]
      && !s.mode[PARITY_EN] && !s.mode[MULTIPROC] && s.txHalf[4:1] == 4'd8
      |-> s.txd)
      else $error("bit 7 shifted out in 7-bit mode");

   sync_nostart_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(s.tx == TX_SEND) && syncMode |-> s.txd == $past(built[0])
      ##1 !s.sclk)
      else $error("sync frame started wrongly");

   clk_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
      !s.ctrl[CTL_CLK_ON] && !s.mode[MODE_TOP] ##1 !s.ctrl[CTL_CLK_ON]
      |-> !cardClk)
      else $error("card clock held without alternate timing");

   status_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
      txFire |=> s.status[ST_TXEND] ##1 s.status[ST_TXEND] || $past(doWrite))
      else $error("transmit end flag lost");

endmodule : serial_mode_config

// ==== bench/serial_peer.sv ====
module serial_peer
(
   input  wire logic        clock,
   input  wire logic        txd,
   input  wire logic [15:0] bitClocks,
   output logic [11:0]      seen,
   output logic             got,
   output logic             rxd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Samples mid-bit, so start skew of less than one half tick still lands in the bit
   initial
   begin
      rxd  = 1'b1;
      got  = 1'b0;
      seen = '0;
      // Got stays up until the next frame starts, so a late look finds it
      forever
      begin
         @(negedge txd);
         got = 1'b0;
         repeat (bitClocks / 2) @(posedge clock);
         for (int i = 0; i < 12; i++)
         begin
            seen[i] = txd;
            repeat (bitClocks) @(posedge clock);
         end
         got = 1'b1;
      end
   end

   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock);
         rxd <= bits[i];
         repeat (bitClocks - 1) @(posedge clock);
      end
      @(posedge clock);
      rxd <= 1'b1;
   endtask : send
endmodule : serial_peer

// ==== bench/tb.sv ====
module tb
   import serial_mode_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock;
   logic        rst_n;
   axiReq_s     axiReq;
   axiResp_s    axiResp;
   logic        rxd;
   logic        txd;
   logic        serialClk;
   logic        cardClk;
   logic        irq;
   logic [15:0] bitClocks;
   logic [11:0] seen;
   logic        got;
   logic [1:0]  writeResp;
   int          fails;
   int          n_compared;

   localparam logic [7:0] MODES [10] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08,
      8'h04, 8'h3C, 8'h01, 8'h02, 8'h03};

   serial_mode_config u_serial_mode_config (.clock(clock), .rst_n(rst_n),
      .axiReq(axiReq), .axiResp(axiResp), .rxd(rxd), .txd(txd),
      .serialClk(serialClk), .cardClk(cardClk), .irq(irq));

   serial_peer u_serial_peer (.clock(clock), .txd(txd),
      .bitClocks(bitClocks), .seen(seen), .got(got), .rxd(rxd));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic finish_test();
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] s, input logic [31:0] e,
                        input string msg);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("[FAIL] %0t %s: got %h want %h", $time, msg, s, e);
      end
   endtask : check

   task automatic tick(inout int n, input int lim);
      @(negedge clock);
      n++;
      if (n > lim)
      begin
         fails++;
         $display("[FAIL] %0t wait timed out", $time);
         finish_test();
      end
   endtask : tick

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      int   n;
      logic aw;
      logic w;
      logic b;
      n = 0;
      @(posedge clock);
      axiReq.awaddr  <= a;
      axiReq.awvalid <= 1'b1;
      axiReq.wdata   <= d;
      axiReq.wstrb   <= 4'hF;
      axiReq.wvalid  <= 1'b1;
      axiReq.bready  <= 1'b1;
      do
      begin
         tick(n, 50);
         aw = axiReq.awvalid && (axiResp.awready === 1'b1);
         w  = axiReq.wvalid && (axiResp.wready === 1'b1);
         b  = (axiResp.bvalid === 1'b1);
         if (b) writeResp = axiResp.bresp;
         @(posedge clock);
         if (aw) axiReq.awvalid <= 1'b0;
         if (w) axiReq.wvalid <= 1'b0;
         if (b) axiReq.bready <= 1'b0;
      end
      while (!b);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int   n;
      logic ar;
      logic v;
      n = 0;
      @(posedge clock);
      axiReq.araddr  <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready  <= 1'b1;
      do
      begin
         tick(n, 50);
         ar = axiReq.arvalid && (axiResp.arready === 1'b1);
         v  = (axiResp.rvalid === 1'b1);
         d  = axiResp.rdata;
         r  = axiResp.rresp;
         @(posedge clock);
         if (ar) axiReq.arvalid <= 1'b0;
         if (v) axiReq.rready <= 1'b0;
      end
      while (!v);
   endtask : rd

   task automatic rdc(input logic [15:0] a, input logic [31:0] e,
                      input logic [31:0] m, input string msg);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d & m, e, msg);
   endtask : rdc

   function automatic logic [11:0] framebits(input logic [7:0] m,
                                             input logic [8:0] d,
                                             output int nb);
      logic [11:0] f;
      int          k;
      f    = '1;
      f[0] = 1'b0;
      k    = 1;
      for (int i = 0; i < (m[CHAR7] ? 7 : 8); i++)
      begin
         f[k] = d[i];
         k++;
      end
      if (m[PARITY_EN])
      begin
         f[k] = ^d[6:0] ^ (m[CHAR7] ? 1'b0 : d[7]) ^ m[PARITY_ODD];
         k++;
      end
      if (m[MULTIPROC])
      begin
         f[k] = d[8];
         k++;
      end
      nb = k + (m[STOP2] ? 2 : 1);
      return f;
   endfunction : framebits

   task automatic frame(input logic [7:0] m, input logic [8:0] d,
                        input logic [31:0] ctl, input int halves);
      int          n;
      int          nb;
      int          pre;
      logic [11:0] ex;
      ex  = framebits(m, d, nb);
      pre = 1 << (2 * m[1:0]);
      if (halves == 0) halves = 2 * nb;
      bitClocks = 16'(16 * pre);
      wr(CTRL_OFF, ctl);
      wr(MODE_OFF, {24'h00_0000, m});
      wr(STAT_OFF, 32'h0000_000F);
      wr(MASK_OFF, 32'h0000_0001);
      wr(TXD_OFF, {23'h00_0000, d});
      n = 0;
      while (txd !== 1'b0) tick(n, 40 * pre);
      n = 0;
      while (irq !== 1'b1) tick(n, 300 * pre);
      n = (n + 4 * pre) / (8 * pre);
      check(n, halves, "length");
      n = 0;
      while (got !== 1'b1) tick(n, 64 * pre);
      if (!ctl[CTL_SMART]) check(seen, ex, "frame bits");
   endtask : frame

   task automatic edges(ref logic s, input int cyc, output int falls,
                        output int changes);
      logic p;
      // Serial clock idles high, card clock low unless a fixed level is set; avoids reading them on a clock edge
      p       = 1'b1;
      falls   = 0;
      changes = 0;
      repeat (cyc)
      begin
         @(negedge clock);
         if (s !== p) changes++;
         if (p === 1'b1 && s === 1'b0) falls++;
         p = s;
      end
   endtask : edges

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      int          f;
      int          c;
      rst_n      = 1'b0;
      axiReq     = '0;
      bitClocks  = 16'h0010;
      fails      = 0;
      n_compared = 0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rdc(MODE_OFF, 32'h0000_0000, '1, "mode reset");
      rdc(CTRL_OFF, 32'h0000_0700, '1, "ctrl reset");
      rdc(MASK_OFF, 32'h0000_0000, '1, "mask reset");
      wr(MODE_OFF, 32'h0000_00FF);
      check(writeResp, RESP_OKAY, "write resp");
      rdc(MODE_OFF, 32'h0000_00FF, '1, "mode readback");
      wr(MODE_OFF, 32'h0000_005A);
      rdc(MODE_OFF, 32'h0000_005A, '1, "mode readback");
      rd(16'hFF7C, d, r);
      check(r, RESP_SLVERR, "unmapped resp");
      check(d, 32'h0000_0000, "unmapped data");
      wr(16'hFF7C, 32'h0000_0000);
      check(writeResp, RESP_SLVERR, "unmapped write resp");
      for (int i = 0; i < 10; i++)
         frame(MODES[i], (i == 6) ? 9'h1A5 : 9'h05A, 32'h0000_0700, 0);
      frame(8'h00, 9'h05A, 32'h0000_0701, 25);
      frame(8'h80, 9'h05A, 32'h0000_0701, 22);
      wr(MASK_OFF, 32'h0000_0000);
      check(irq, 1'b0, "masked irq");
      rdc(STAT_OFF, 32'h0000_0001, 32'h0000_0001, "tx end sticky");
      wr(STAT_OFF, 32'h0000_0001);
      rdc(STAT_OFF, 32'h0000_0000, 32'h0000_0001, "tx end cleared");
      // Fixed level applies only while the card clock is switched off
      wr(CTRL_OFF, 32'h0000_070D);
      wr(MODE_OFF, 32'h0000_0080);
      edges(cardClk, 32, f, c);
      check(c, 0, "card clock held");
      check(cardClk, 1'b1, "card clock level");
      wr(MODE_OFF, 32'h0000_0000);
      @(negedge clock);
      check(cardClk, 1'b0, "no fixed level");
      wr(CTRL_OFF, 32'h0000_070F);
      edges(cardClk, 32, f, c);
      check(c > 0, 1'b1, "card clock runs");
      wr(CTRL_OFF, 32'h0000_0700);
      wr(MODE_OFF, 32'h0000_0080);
      wr(TXD_OFF, 32'h0000_00A5);
      edges(serialClk, 188, f, c);
      check(f, 8, "sync bit clocks");
      wr(MODE_OFF, 32'h0000_0020);
      wr(MASK_OFF, 32'h0000_0002);
      bitClocks = 16'h0010;
      for (int p = 0; p < 2; p++)
      begin
         wr(STAT_OFF, 32'h0000_000F);
         u_serial_peer.send({1'b1, 1'(p), 8'h01, 1'b0}, 11);
         c = 0;
         while (irq !== 1'b1) tick(c, 400);
         rdc(STAT_OFF, p ? 32'h0000_0002 : 32'h0000_0006, 32'h0000_000F,
             "rx status");
         rdc(RXD_OFF, 32'h0000_0001, 32'h0000_00FF, "rx data");
      end
      finish_test();
   end
endmodule : tb
